// ===== logic/efh_host.v
`timescale 1ns/10ps
`include "efh_map.vh"
// host side controller for one framer die group: runs the parallel port,
// makes backplane clocks and sync, feeds transmit data with stores on, samples receive data
module efh_host (
    // clock and reset
    input wire clock_in,
    input wire reset_in,
    // user command port
    input wire cmd_valid_in,
    input wire cmd_write_in,
    input wire [1:0] cmd_die_in,
    input wire [1:0] cmd_framer_in,
    input wire [7:0] cmd_addr_in,
    input wire [7:0] cmd_wdata_in,
    output wire cmd_ready_out,
    output reg rsp_valid_out,
    output reg [7:0] rsp_rdata_out,
    // straps
    input wire mux_mode_in,
    input wire bus_style_in,
    // parallel port pins
    output reg [2:0] die_select_n_out,
    output reg [1:0] framer_select_out,
    output reg [6:0] host_addr_bus_out,
    output reg addr_latch_strobe_out,
    output reg read_strobe_out,
    output reg write_strobe_out,
    output reg [7:0] host_data_bus_out,
    output reg host_data_bus_oe_out,
    input wire [7:0] host_data_bus_in,
    input wire irq_n_in,
    output wire irq_pending_out,
    // backplane side
    input wire bp_enable_in,
    output reg tx_backplane_clock_out,
    output reg tx_backplane_sync_out,
    output reg rx_backplane_clock_out,
    input wire tx_data_in,
    output reg tx_serial_out,
    input wire tx_line_clock_in,
    input wire rx_line_clock_in,
    input wire rx_serial_in,
    input wire rx_multiframe_sync_in,
    output reg rx_serial_bit_out,
    output reg rx_bit_valid_out,
    output reg rx_multiframe_out,
    // frame length in backplane clocks for sync pulses
    input wire [7:0] frame_bits_in
);
    // host bus state machine, one-hot
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_ALE = 6'h02;
    localparam [5:0] ST_SETUP = 6'h04;
    localparam [5:0] ST_STROBE = 6'h08;
    localparam [5:0] ST_HOLD = 6'h10;
    localparam [5:0] ST_DONE = 6'h20;
    reg [5:0] state; // current bus phase
    reg [3:0] phase_cnt; // cycles within phase
    reg cmd_write; // latched direction
    reg [1:0] cmd_die; // latched die
    reg [7:0] cmd_addr; // latched address
    reg [7:0] cmd_wdata; // latched write data
    reg [2:0] bp_div; // backplane divider
    reg [7:0] bit_cnt; // bits within frame
    reg [2:0] irq_sync; // interrupt synchroniser
    reg [1:0] tclk_sync; // tx line clock synchroniser
    reg tclk_last; // previous synced tx clock
    reg [1:0] rclk_sync; // rx line clock synchroniser
    reg rclk_last; // previous synced rx clock
    reg [1:0] rser_sync; // rx data synchroniser
    reg [1:0] rms_sync; // rx multiframe synchroniser
    wire phase_end; // phase counter expired
    wire bp_rise; // backplane clock rising this cycle
    wire bp_fall; // backplane clock falling this cycle
    wire rclk_rise; // rising edge of rx line clock
    wire tclk_fall; // falling edge of tx line clock
    wire [2:0] die_onehot_n; // decoded die select

    assign cmd_ready_out = (state == ST_IDLE);
    assign phase_end = (phase_cnt == `EFH_PHASE_CYCLES);
    assign bp_rise = bp_enable_in && (bp_div == `EFH_BP_HALF);
    assign bp_fall = bp_enable_in && (bp_div == (`EFH_BP_DIV - 3'h1));
    assign rclk_rise = rclk_sync[1] && !rclk_last;
    assign tclk_fall = !tclk_sync[1] && tclk_last; // RULE_04
    assign die_onehot_n = ~(3'h1 << cmd_die);
    assign irq_pending_out = !irq_sync[2];

    ////////////////////////////////////////////////////////////////////////////////
    // parallel port access sequence
    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            state <= ST_IDLE;
            phase_cnt <= 4'h0;
            cmd_write <= 1'b0;
            cmd_die <= 2'h0;
            cmd_addr <= 8'h00;
            cmd_wdata <= 8'h00;
            die_select_n_out <= 3'h7;
            framer_select_out <= 2'h0;
            host_addr_bus_out <= 7'h00;
            addr_latch_strobe_out <= 1'b0;
            read_strobe_out <= 1'b1;
            write_strobe_out <= 1'b1;
            host_data_bus_out <= 8'h00;
            host_data_bus_oe_out <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= 8'h00;
        end else begin
            rsp_valid_out <= 1'b0;
            phase_cnt <= phase_end ? 4'h0 : phase_cnt + 4'h1;
            case (state)
                ST_IDLE: begin
                    phase_cnt <= 4'h0;
                    // idle strobes per style
                    read_strobe_out <= !bus_style_in; // RULE_20
                    write_strobe_out <= 1'b1;
                    addr_latch_strobe_out <= 1'b0;
                    // multiplexed: separate address pins go low on the clock after the strap is seen while idle
                    if (mux_mode_in) begin
                        host_addr_bus_out <= 7'h00; // RULE_17
                    end
                    if (cmd_valid_in) begin
                        cmd_write <= cmd_write_in;
                        cmd_die <= cmd_die_in;
                        cmd_addr <= cmd_addr_in;
                        cmd_wdata <= cmd_wdata_in;
                        framer_select_out <= cmd_framer_in; // RULE_21
                        state <= mux_mode_in ? ST_ALE : ST_SETUP;
                    end
                end
                ST_ALE: begin
                    // multiplexed: address on shared bus, separate pins low
                    host_addr_bus_out <= 7'h00; // RULE_17
                    host_data_bus_out <= cmd_addr;
                    host_data_bus_oe_out <= 1'b1;
                    addr_latch_strobe_out <= (phase_cnt != 4'h0); // RULE_18
                    if (phase_end) begin
                        state <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    die_select_n_out <= die_onehot_n; // RULE_22
                    if (!mux_mode_in) begin
                        // separate buses; latch pin carries address bit 6
                        host_addr_bus_out <= {cmd_addr[7], cmd_addr[5:0]}; // RULE_17
                        addr_latch_strobe_out <= cmd_addr[6]; // RULE_18
                    end else begin
                        addr_latch_strobe_out <= 1'b0;
                    end
                    // write direction pin in data strobe style
                    if (bus_style_in) begin
                        write_strobe_out <= !cmd_write; // RULE_19
                    end
                    host_data_bus_out <= cmd_wdata;
                    host_data_bus_oe_out <= cmd_write; // RULE_23
                    if (phase_end) begin
                        state <= ST_STROBE;
                    end
                end
                ST_STROBE: begin
                    if (bus_style_in) begin
                        read_strobe_out <= 1'b1; // RULE_19
                    end else if (cmd_write) begin
                        write_strobe_out <= 1'b0;
                    end else begin
                        read_strobe_out <= 1'b0; // RULE_20
                    end
                    if (phase_end) begin
                        rsp_rdata_out <= host_data_bus_in;
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    read_strobe_out <= !bus_style_in;
                    if (!bus_style_in) begin
                        write_strobe_out <= 1'b1;
                    end
                    if (phase_end) begin
                        die_select_n_out <= 3'h7;
                        host_data_bus_oe_out <= 1'b0;
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    write_strobe_out <= 1'b1;
                    rsp_valid_out <= 1'b1;
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // backplane clocks and frame sync from divider
    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            bp_div <= 3'h0;
            bit_cnt <= 8'h00;
            tx_backplane_clock_out <= 1'b0;
            rx_backplane_clock_out <= 1'b0;
            tx_backplane_sync_out <= 1'b0;
            tx_serial_out <= 1'b0;
        end else begin
            bp_div <= (bp_div == (`EFH_BP_DIV - 3'h1)) ? 3'h0 : bp_div + 3'h1;
            // held low when stores are unused
            if (!bp_enable_in) begin
                tx_backplane_clock_out <= 1'b0; // RULE_03
                rx_backplane_clock_out <= 1'b0; // RULE_13
                tx_backplane_sync_out <= 1'b0; // RULE_05
            end else if (bp_rise) begin
                tx_backplane_clock_out <= 1'b1;
                rx_backplane_clock_out <= 1'b1;
            end else if (bp_fall) begin
                // change data and sync away from the device's falling sample
                tx_backplane_clock_out <= 1'b0;
                rx_backplane_clock_out <= 1'b0;
            end
            // data and sync change after rising edge, stable at falling
            if (bp_rise) begin
                bit_cnt <= (bit_cnt >= frame_bits_in - 8'h01) ? 8'h00 : bit_cnt + 8'h01;
                tx_backplane_sync_out <= (bit_cnt == 8'h00); // RULE_05
                tx_serial_out <= tx_data_in; // RULE_02
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // synchronisers for pins from the device
    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            irq_sync <= 3'h7;
            tclk_sync <= 2'h0;
            tclk_last <= 1'b0;
            rclk_sync <= 2'h0;
            rclk_last <= 1'b0;
            rser_sync <= 2'h0;
            rms_sync <= 2'h0;
        end else begin
            irq_sync <= {irq_sync[1:0], irq_n_in}; // RULE_16
            tclk_sync <= {tclk_sync[0], tx_line_clock_in};
            tclk_last <= tclk_sync[1];
            rclk_sync <= {rclk_sync[0], rx_line_clock_in};
            rclk_last <= rclk_sync[1];
            rser_sync <= {rser_sync[0], rx_serial_in};
            rms_sync <= {rms_sync[0], rx_multiframe_sync_in};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // receive data capture on rising edge of line clock or falling edge of backplane clock
    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            rx_serial_bit_out <= 1'b0;
            rx_bit_valid_out <= 1'b0;
            rx_multiframe_out <= 1'b0;
        end else begin
            rx_bit_valid_out <= 1'b0;
            // with stores on, receive timing follows the backplane clock
            if (bp_enable_in ? bp_fall : rclk_rise) begin // RULE_11
                rx_serial_bit_out <= rser_sync[1]; // RULE_09
                rx_multiframe_out <= rms_sync[1]; // RULE_12
                rx_bit_valid_out <= 1'b1;
            end else if (tclk_fall) begin
                rx_multiframe_out <= rx_multiframe_out;
            end
        end
    end
endmodule // efh_host

// ===== logic/efh_map.vh
// Notes on behaviour
// RULE_01 - device moves transmit data on line clock
// RULE_02 - transmit data sampled on falling clock edge
// RULE_03 - backplane clock used only with elastic store
// RULE_04 - transmit sync pulse sets frame boundaries
// RULE_05 - backplane sync pulse sets boundaries with store
// RULE_06 - transmit line outputs update on rising edge
// RULE_07 - control bit seven selects nrz transmit output
// RULE_08 - receive framer runs on receive line clock
// RULE_09 - receive serial output updates on rising edge
// RULE_10 - receive sync pulse one line clock wide
// RULE_11 - receive sync may be input with store
// RULE_12 - multiframe sync pulses one backplane clock wide
// RULE_13 - receive backplane clock used only with store
// RULE_14 - receive line inputs sampled on falling edge
// RULE_15 - tied rails give no bipolar violation flags
// RULE_16 - interrupt is active low open drain
// RULE_17 - bus mode selects multiplexed or separate buses
// RULE_18 - latch strobe captures address in multiplexed mode
// RULE_19 - bus style strap sets strobe meanings
// RULE_20 - read strobe low or high per style
// RULE_21 - host drives framer select for one framer
// RULE_22 - chip select low for every access; an access to die 3 drives no chip select low
// RULE_23 - device drives data only during reads
`ifndef EFH_MAP_VH
`define EFH_MAP_VH
// transmit control one offset and output format bit
`define EFH_TX_CONTROL_ONE_ADDR 8'h12
`define EFH_TX_CONTROL_NRZ_BIT 7
// host bus phase end count; each phase lasts one system clock more than this
`define EFH_PHASE_CYCLES 4'h2
// backplane clock divider: 10 MHz / 5 = 2 MHz
`define EFH_BP_DIV 3'h5
`define EFH_BP_HALF 3'h2
`endif

// ===== test/efh_host_sva.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////
// protocol checker on the controller ports
module efh_host_sva (
    // clock and reset
    input wire clock_in,
    input wire reset_in,
    // user port
    input wire cmd_valid_in,
    input wire cmd_ready_out,
    input wire rsp_valid_out,
    // straps and pins
    input wire mux_mode_in,
    input wire bus_style_in,
    input wire [2:0] die_select_n_out,
    input wire [6:0] host_addr_bus_out,
    input wire read_strobe_out,
    input wire write_strobe_out,
    input wire host_data_bus_oe_out,
    input wire irq_n_in,
    input wire irq_pending_out,
    input wire bp_enable_in,
    input wire tx_backplane_clock_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    // read strobe active in either style
    wire rd_on = bus_style_in ? read_strobe_out & write_strobe_out : !read_strobe_out;
    // access taken this edge
    wire take = cmd_valid_in & cmd_ready_out;
    a_no_bus_fight: assert property (host_data_bus_oe_out |-> !rd_on)
        else $error("host drives bus in read");
    a_sel_onehot: assert property ($onehot0(~die_select_n_out))
        else $error("two dies selected");
    a_mux_addr_low: assert property (mux_mode_in && $past(mux_mode_in) |-> host_addr_bus_out == 7'h00)
        else $error("address pins not low");
    a_answer_sep: assert property (take && !mux_mode_in |-> ##11 rsp_valid_out)
        else $error("separate bus answer late");
    a_answer_mux: assert property (take && mux_mode_in |-> ##14 rsp_valid_out)
        else $error("mux bus answer late");
    a_busy_after: assert property (take |=> !cmd_ready_out [*8])
        else $error("second request taken");
    a_rsp_single: assert property (rsp_valid_out |=> !rsp_valid_out && cmd_ready_out)
        else $error("answer not single");
    a_irq_follow: assert property (!irq_n_in [*5] |-> irq_pending_out)
        else $error("interrupt not seen");
    a_irq_clear: assert property (irq_n_in [*5] |-> !irq_pending_out)
        else $error("interrupt not cleared");
    a_bp_quiet: assert property (!bp_enable_in [*8] |-> !tx_backplane_clock_out)
        else $error("backplane clock runs");
    c_mux: cover property (take && mux_mode_in);
    c_ds: cover property (take && bus_style_in);
    c_irq: cover property ($rose(irq_pending_out));
endmodule // efh_host_sva
bind efh_host efh_host_sva efh_host_sva_i (.*);

// ===== test/efh_dev_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////
// one framer die: register file behind the parallel port
module efh_dev_model (
    // port pins
    input wire die_select_n_in,
    input wire [1:0] framer_select_in,
    input wire [6:0] host_addr_bus_in,
    input wire addr_latch_strobe_in,
    input wire read_strobe_in,
    input wire write_strobe_in,
    input wire [7:0] host_data_bus_in,
    input wire mux_mode_in,
    input wire bus_style_in,
    // driven data and interrupt level
    output wire [7:0] dev_data_out,
    output wire dev_oe_out,
    output wire irq_n_out
);
    reg [7:0] mem [0:1023]; // four framers of 256 bytes
    reg [7:0] latched; // address taken from shared bus
    integer i;
    // separate address, latch pin is bit 6
    wire [7:0] addr = mux_mode_in ? latched : {host_addr_bus_in[6], addr_latch_strobe_in,
        host_addr_bus_in[5:0]};
    // strobe meaning set by style strap
    wire rd = bus_style_in ? read_strobe_in & write_strobe_in : !read_strobe_in;
    wire wr = bus_style_in ? read_strobe_in & !write_strobe_in : !write_strobe_in;
    initial begin
        for (i = 0; i < 1024; i = i + 1) mem[i] = i[7:0] ^ 8'h16;
    end
    // latch address on rising strobe edge
    always @(posedge addr_latch_strobe_in) if (mux_mode_in) latched <= host_data_bus_in;
    // write commits at strobe end
    always @(negedge wr) if (!die_select_n_in) mem[{framer_select_in, addr}] <= host_data_bus_in;
    assign dev_oe_out = rd & !die_select_n_in;
    assign dev_data_out = mem[{framer_select_in, addr}];
    assign irq_n_out = mem[10'h016] == 8'h00;
endmodule // efh_dev_model

// ===== test/efh_host_tb.sv
`timescale 1ns/10ps
`include "efh_map.vh"
////////////////////////////////////////////////////////////
// bench: controller against one die model
module efh_host_tb;
    reg clock_in = 0, reset_in = 1, cmd_valid_in = 0, cmd_write_in = 0, mux_mode_in = 0, bus_style_in = 0;
    reg [1:0] cmd_die_in = 0, cmd_framer_in = 0;
    reg [7:0] cmd_addr_in = 0, cmd_wdata_in = 0, frame_bits_in = 8'h20, shadow [0:1023];
    reg bp_enable_in = 0, tx_data_in = 0, rx_serial_in = 0, rx_multiframe_sync_in = 0, flip = 0;
    reg tx_line_clock_in = 0, rx_line_clock_in = 0;
    reg [1:0] f;
    reg [7:0] a, d;
    integer samples_checked = 0, miscompares = 0, cyc = 0, i, m;
    wire cmd_ready_out, rsp_valid_out, addr_latch_strobe_out, read_strobe_out, write_strobe_out;
    wire host_data_bus_oe_out, irq_pending_out, tx_backplane_clock_out, dev_oe, irq_n_in;
    wire rx_bit_valid_out, tx_backplane_sync_out, rx_backplane_clock_out;
    wire [7:0] rsp_rdata_out, host_data_bus_out, dev_q, host_data_bus_in;
    wire [2:0] die_select_n_out;
    wire [1:0] framer_select_out;
    wire [6:0] host_addr_bus_out;
    // bus level: device, host, else a changing pattern
    assign host_data_bus_in = dev_oe ? dev_q : host_data_bus_oe_out ? host_data_bus_out : {8{flip}};
    efh_host efh_host_i (.tx_serial_out(), .rx_serial_bit_out(), .rx_multiframe_out(), .*);
    efh_dev_model efh_dev_model_i (.die_select_n_in(die_select_n_out[0]), .framer_select_in(framer_select_out),
        .host_addr_bus_in(host_addr_bus_out), .addr_latch_strobe_in(addr_latch_strobe_out),
        .read_strobe_in(read_strobe_out), .write_strobe_in(write_strobe_out), .host_data_bus_in(host_data_bus_in),
        .mux_mode_in(mux_mode_in), .bus_style_in(bus_style_in), .dev_data_out(dev_q), .dev_oe_out(dev_oe),
        .irq_n_out(irq_n_in));
    always #50 clock_in = ~clock_in;
    // line clocks, phase unrelated to the system clock
    initial #13 forever #400 tx_line_clock_in = ~tx_line_clock_in;
    always @(tx_line_clock_in) rx_line_clock_in <= #170 tx_line_clock_in;
    // random serial traffic and hang guard
    always @(posedge clock_in) begin
        tx_data_in <= 1'($urandom);
        rx_serial_in <= 1'($urandom);
        rx_multiframe_sync_in <= 6'($urandom) == 6'h00;
        flip <= ~flip;
        cyc = cyc + 1;
        if (cyc == 20000) begin
            miscompares = miscompares + 1;
            end_of_test;
        end
    end
    // count and report one comparison
    task chk(input ok, input [8*16-1:0] msg);
        begin
            samples_checked = samples_checked + 1;
            if (!ok) begin
                miscompares = miscompares + 1;
                $display("MISMATCH %0t %0s", $time, msg);
            end
        end
    endtask
    // one byte access, latency and read data checked
    task acc(input w, input [1:0] di, input [1:0] fr, input [7:0] ad, input [7:0] wd);
        integer n;
        begin
            cmd_valid_in <= 1'h1;
            cmd_write_in <= w;
            cmd_die_in <= di;
            cmd_framer_in <= fr;
            cmd_addr_in <= ad;
            cmd_wdata_in <= wd;
            @(posedge clock_in);
            cmd_valid_in <= 1'h0;
            n = 0;
            while (rsp_valid_out !== 1'h1 && n < 40) begin
                @(negedge clock_in);
                n = n + 1;
            end
            chk(n == (mux_mode_in ? 14 : 11), "latency");
            if (!w && di == 2'h0) chk(rsp_rdata_out === shadow[{fr, ad}], "read data");
            @(posedge clock_in);
        end
    endtask
    // write die 0 and track expected contents
    task wr0(input [1:0] fr, input [7:0] ad, input [7:0] wd);
        begin
            acc(1'h1, 2'h0, fr, ad, wd);
            shadow[{fr, ad}] = wd;
        end
    endtask
    // rising backplane clock edges over 50 cycles
    task bp_count(input e, input integer ex, input integer ev);
        integer k, c, v, s, x;
        reg p;
        begin
            bp_enable_in <= e;
            repeat (10) @(posedge clock_in);
            c = 0;
            v = 0;
            s = 0;
            x = 0;
            p = tx_backplane_clock_out;
            for (k = 0; k < 50; k = k + 1) begin
                @(negedge clock_in);
                if (tx_backplane_clock_out && !p) c = c + 1;
                if (rx_bit_valid_out === 1'h1) v = v + 1;
                if (tx_backplane_sync_out !== 1'h0) s = s + 1;
                if (rx_backplane_clock_out !== tx_backplane_clock_out) x = x + 1;
                p = tx_backplane_clock_out;
            end
            chk(c >= ex - 1 && c <= ex + 1, "bp clock rate");
            chk(v >= ev - 1 && v <= ev + 1, "rx bit rate");
            chk(x == 0, "rx bp clock");
            chk(e || s == 0, "bp sync idle");
            @(posedge clock_in);
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", samples_checked, miscompares);
            if (miscompares == 0 && samples_checked > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // main sequence over every mode and strobe style
    initial begin
        i = $urandom(32'h3909ca42);
        for (i = 0; i < 1024; i = i + 1) shadow[i] = i[7:0] ^ 8'h16;
        repeat (2) @(posedge clock_in);
        reset_in <= 1'h0;
        @(posedge clock_in);
        for (m = 0; m < 4; m = m + 1) begin
            mux_mode_in <= m[0];
            bus_style_in <= m[1];
            @(posedge clock_in);
            wr0(2'h0, `EFH_TX_CONTROL_ONE_ADDR, 8'h80);
            acc(1'h0, 2'h0, 2'h0, `EFH_TX_CONTROL_ONE_ADDR, 8'h00);
            repeat (5) begin
                f = 2'($urandom);
                a = 8'($urandom);
                d = 8'($urandom);
                bp_enable_in <= 1'($urandom);
                wr0(f, a, d);
                acc(1'h0, 2'h0, f, a, 8'h00);
                acc(1'h1, 2'h3, f, a, ~d);
                acc(1'h0, 2'h0, f, a, 8'h00);
            end
            wr0(2'h0, 8'h16, 8'h01);
            repeat (6) @(posedge clock_in);
            chk(irq_pending_out === 1'h1, "irq set");
            wr0(2'h0, 8'h16, 8'h00);
            repeat (6) @(posedge clock_in);
            chk(irq_pending_out === 1'h0, "irq clear");
        end
        bp_count(1'h0, 0, 6);
        bp_count(1'h1, 50 / `EFH_BP_DIV, 50 / `EFH_BP_DIV);
        end_of_test;
    end
endmodule // efh_host_tb
